// ---- rtl/bist_cont_map.svh ----
// Constants for the continuous self-test mode controller
`ifndef BIST_CONT_MAP_SVH
`define BIST_CONT_MAP_SVH
`define TEST_TIME_US 32'd60000
`define CLOCK_MHZ 32'd40
`define TIMER_WIDTH 32
`define MODE_NONE 3'h0
`define MODE_EYE 3'h1
`define MODE_CARRIER0 3'h2
`define MODE_CARRIER1 3'h3
`define MODE_CARRIER2 3'h4
`define MODE_CARRIER3 3'h5
`define ROLE_SOURCE 2'h0
`define ROLE_SINK 2'h1
`define ROLE_CABLE 2'h2
`endif

// ---- rtl/bist_cont_pkg.sv ----
// Types for the continuous self-test mode controller
package bist_cont_pkg;
	typedef enum logic [3:0] {
		SourceReady, SinkReady, CableReady, EyeTest, Carrier0Test, Carrier1Test,
		Carrier2Test, Carrier3Test, ReturnDefault, DisconnectRecover
	} peState_t;
	typedef struct packed {
		peState_t state;
		logic [31:0] timer;
		logic [2:0] protoMode;
		logic toDefault;
		logic disconnect;
		logic contractActive;
		logic testActive;
	} state_t;
endpackage : bist_cont_pkg

// ---- rtl/bist_continuous_mode_control.sv ----
// Policy-engine control of the continuous self-test modes and disconnect recovery
`timescale 1ns/10ps
`include "bist_cont_map.svh"
module bist_continuous_mode_control #(
	parameter int TEST_CYCLES = `TEST_TIME_US * `CLOCK_MHZ
) (
	input wire logic clock, // 40 MHz clock
	input wire logic resetn, // Async reset, active low
	input wire logic clockEnable, // Freezes all state when low
	input wire logic [1:0] portRole, // Source, sink or cable
	input wire logic testRequest, // Test request message pulse
	input wire logic [2:0] requestMode, // Requested test mode
	input wire logic busAtSafeLevel, // Bus at safe default level
	input wire logic operatorReset, // Operator reset of the unit
	input wire logic hardResetRx, // Hard reset signalling received
	input wire logic fatalError, // Error hard reset cannot fix
	input wire logic reconnected, // Partners reconnected over CC
	input wire logic contractMade, // Explicit contract established
	input wire logic defaultDone, // Transition to default finished
	output logic [2:0] protocolMode, // Test mode for protocol layer
	output logic testActive, // A continuous mode is running
	output logic toDefault, // In return-to-default state
	output logic disconnect, // Electrical disconnect request
	output logic contractActive, // Power contract in force
	output logic [3:0] peState // Current state code
);
	bist_cont_pkg::state_t cur_reg, cur_next;
	logic inReady, enterTest, leaveTest;

	// Idle ready state for a given role
	function automatic bist_cont_pkg::peState_t readyOf(input logic [1:0] role);
		if (role == `ROLE_CABLE) return bist_cont_pkg::CableReady;
		if (role == `ROLE_SINK) return bist_cont_pkg::SinkReady;
		return bist_cont_pkg::SourceReady;
	endfunction : readyOf

	// Exit target after a test mode
	function automatic bist_cont_pkg::peState_t exitOf(input logic [1:0] role);
		if (role == `ROLE_CABLE) return bist_cont_pkg::CableReady;
		return bist_cont_pkg::ReturnDefault;
	endfunction : exitOf

	// Entry and exit qualifiers
	// Port sits in one of the three ready states
	assign inReady = (cur_reg.state == bist_cont_pkg::SourceReady) ||
		(cur_reg.state == bist_cont_pkg::SinkReady) || (cur_reg.state == bist_cont_pkg::CableReady);
	// Valid request on a safe bus, nothing fatal pending
	assign enterTest = inReady && testRequest && busAtSafeLevel && !fatalError &&
		(requestMode != `MODE_NONE) && (requestMode <= `MODE_CARRIER3);
	// Timer expiry, operator reset or hard reset ends a test
	assign leaveTest = (cur_reg.timer == 32'h0) || operatorReset || hardResetRx;

	// Next-state logic
	always_comb begin
		cur_next = cur_reg;
		// Fatal error overrides every state
		if (fatalError) begin
			cur_next.state = bist_cont_pkg::DisconnectRecover;
			cur_next.protoMode = `MODE_NONE;
			cur_next.testActive = 1'b0;
			cur_next.disconnect = 1'b1;
			cur_next.contractActive = 1'b0;
			cur_next.toDefault = 1'b0;
		end else begin
			case (cur_reg.state)
				bist_cont_pkg::SourceReady, bist_cont_pkg::SinkReady,
				bist_cont_pkg::CableReady: begin
					if (contractMade) cur_next.contractActive = 1'b1;
					if (enterTest) begin
						// One mode at a time, timer loaded on entry
						cur_next.protoMode = requestMode;
						cur_next.timer = TEST_CYCLES[31:0] - 32'h1;
						cur_next.testActive = 1'b1;
						case (requestMode)
							`MODE_EYE: cur_next.state = bist_cont_pkg::EyeTest;
							`MODE_CARRIER0: cur_next.state = bist_cont_pkg::Carrier0Test;
							`MODE_CARRIER1: cur_next.state = bist_cont_pkg::Carrier1Test;
							`MODE_CARRIER2: cur_next.state = bist_cont_pkg::Carrier2Test;
							default: cur_next.state = bist_cont_pkg::Carrier3Test;
						endcase
					end else if (cur_reg.state != readyOf(portRole)) begin
						// Follow a role change to its own ready state
						cur_next.state = readyOf(portRole);
					end
				end
				bist_cont_pkg::EyeTest, bist_cont_pkg::Carrier0Test, bist_cont_pkg::Carrier1Test,
				bist_cont_pkg::Carrier2Test, bist_cont_pkg::Carrier3Test: begin
					if (leaveTest) begin
						// Exit to default or cable ready as the role fits
						cur_next.state = exitOf(portRole);
						cur_next.protoMode = `MODE_NONE;
						cur_next.testActive = 1'b0;
						cur_next.toDefault = (portRole != `ROLE_CABLE);
					end else begin
						// Count down one enabled cycle
						cur_next.timer = cur_reg.timer - 32'h1;
					end
				end
				bist_cont_pkg::ReturnDefault: begin
					// Wait for the default transition to finish
					if (defaultDone) begin
						cur_next.state = readyOf(portRole);
						cur_next.toDefault = 1'b0;
					end
				end
				bist_cont_pkg::DisconnectRecover: begin
					// Fresh contract expected once partners reconnect
					if (reconnected) begin
						cur_next.state = readyOf(portRole);
						cur_next.disconnect = 1'b0;
					end
				end
				default: cur_next.state = readyOf(portRole);
			endcase
		end
	end

	// State register
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			// All outputs low, source ready
			cur_reg <= '{state: bist_cont_pkg::SourceReady, timer: 32'h0, protoMode: `MODE_NONE,
				toDefault: 1'b0, disconnect: 1'b0, contractActive: 1'b0, testActive: 1'b0};
		end else if (clockEnable) begin
			cur_reg <= cur_next;
		end
	end

	// Outputs straight from state
	assign protocolMode = cur_reg.protoMode;
	assign testActive = cur_reg.testActive;
	assign toDefault = cur_reg.toDefault;
	assign disconnect = cur_reg.disconnect;
	assign contractActive = cur_reg.contractActive;
	assign peState = cur_reg.state;

	// Checks
	entry_needs_safe_a: assert property (@(posedge clock) disable iff (!resetn)
		(clockEnable && $rose(testActive)) |-> $past(busAtSafeLevel) && $past(testRequest))
		else $error("test entered without safe bus and request");
	mode_matches_req_a: assert property (@(posedge clock) disable iff (!resetn)
		(clockEnable && $rose(testActive)) |-> protocolMode == $past(requestMode))
		else $error("protocol mode differs from request");
	mode_and_active_a: assert property (@(posedge clock) disable iff (!resetn)
		testActive == (protocolMode != `MODE_NONE))
		else $error("active flag and mode disagree");

	// Exit checks
	operator_exit_a: assert property (@(posedge clock) disable iff (!resetn)
		(clockEnable && testActive && operatorReset && !fatalError) |=> !testActive)
		else $error("operator reset did not end test");
	hard_reset_a: assert property (@(posedge clock) disable iff (!resetn)
		(clockEnable && testActive && hardResetRx && !fatalError && portRole != `ROLE_CABLE)
		|=> toDefault)
		else $error("hard reset did not go to default");
	cable_exit_a: assert property (@(posedge clock) disable iff (!resetn)
		(clockEnable && testActive && operatorReset && !fatalError && portRole == `ROLE_CABLE)
		|=> peState == bist_cont_pkg::CableReady && !toDefault)
		else $error("cable did not return to ready");

	// Recovery checks
	recovery_disc_a: assert property (@(posedge clock) disable iff (!resetn)
		(clockEnable && fatalError) |=> disconnect && !testActive)
		else $error("recovery did not disconnect");
	contract_end_a: assert property (@(posedge clock) disable iff (!resetn)
		(clockEnable && fatalError) |=> !contractActive)
		else $error("contract survived recovery");

	// Refusals and state mapping
	no_entry_unsafe_a: assert property (@(posedge clock) disable iff (!resetn)
		(clockEnable && !testActive && !busAtSafeLevel) |=> !testActive)
		else $error("test entered with bus not at safe level");
	eye_state_a: assert property (@(posedge clock) disable iff (!resetn)
		(testActive && protocolMode == `MODE_EYE) |->
		peState == bist_cont_pkg::EyeTest)
		else $error("eye mode not in eye test state");
	carrier0_state_a: assert property (@(posedge clock) disable iff (!resetn)
		(testActive && protocolMode == `MODE_CARRIER0) |->
		peState == bist_cont_pkg::Carrier0Test)
		else $error("carrier 0 mode not in its test state");
	carrier1_state_a: assert property (@(posedge clock) disable iff (!resetn)
		(testActive && protocolMode == `MODE_CARRIER1) |->
		peState == bist_cont_pkg::Carrier1Test)
		else $error("carrier 1 mode not in its test state");
	carrier2_state_a: assert property (@(posedge clock) disable iff (!resetn)
		(testActive && protocolMode == `MODE_CARRIER2) |->
		peState == bist_cont_pkg::Carrier2Test)
		else $error("carrier 2 mode not in its test state");
	carrier3_state_a: assert property (@(posedge clock) disable iff (!resetn)
		(testActive && protocolMode == `MODE_CARRIER3) |->
		peState == bist_cont_pkg::Carrier3Test)
		else $error("carrier 3 mode not in its test state");
	// Timer load and expiry
	timer_load_a: assert property (@(posedge clock) disable iff (!resetn)
		$rose(testActive) |-> cur_reg.timer == TEST_CYCLES[31:0] - 32'h1)
		else $error("test timer not loaded on entry");
	timer_expiry_a: assert property (@(posedge clock) disable iff (!resetn)
		(clockEnable && testActive && cur_reg.timer == 32'h0) |=> !testActive)
		else $error("test outlived its timer");
	// Leaving the default and recovery states
	default_done_a: assert property (@(posedge clock) disable iff (!resetn)
		(clockEnable && peState == bist_cont_pkg::ReturnDefault && defaultDone &&
		!fatalError) |=> !toDefault && !testActive)
		else $error("return to default did not finish");
	recovery_exit_a: assert property (@(posedge clock) disable iff (!resetn)
		(clockEnable && peState == bist_cont_pkg::DisconnectRecover && reconnected &&
		!fatalError) |=> !disconnect && !contractActive)
		else $error("recovery did not release disconnect");

	// Scenario covers
	cover_eye_c: cover property (@(posedge clock) peState == bist_cont_pkg::EyeTest);
	cover_carrier3_c: cover property (@(posedge clock) peState == bist_cont_pkg::Carrier3Test);
	cover_recover_c: cover property (@(posedge clock) peState == bist_cont_pkg::DisconnectRecover);
	cover_default_c: cover property (@(posedge clock) peState == bist_cont_pkg::ReturnDefault);
	cover_cable_exit_c: cover property (@(posedge clock)
		$fell(testActive) && peState == bist_cont_pkg::CableReady);
endmodule : bist_continuous_mode_control

// ---- verification/bist_test_partner.sv ----
// Test equipment model that issues test request messages
`timescale 1ns/10ps
module bist_test_partner (
	input wire logic clock, // Bench clock
	input wire logic sendReq, // Issue one request this cycle
	input wire logic [2:0] reqMode, // Mode carried by the request
	output logic testRequest = 1'b0, // Request message pulse
	output logic [2:0] requestMode = 3'h0 // Mode field, scrambled when idle
);
	// Launch just after the falling edge; an idle mode field keeps toggling
	always @(negedge clock) begin
		#1;
		testRequest <= sendReq;
		requestMode <= sendReq ? reqMode : ~requestMode;
	end
endmodule : bist_test_partner

// ---- verification/bist_continuous_mode_control_tb.sv ----
// Testbench for the continuous self-test mode controller
`timescale 1ns/10ps
module bist_continuous_mode_control_tb;
	logic clock = 1'b0;
	logic resetn = 1'b0;
	logic sendReq = 1'b0;
	logic busAtSafeLevel = 1'b1;
	logic clockEnable = 1'b1;
	logic [5:0] endPulse;
	logic [10:0] outs;
	logic [5:0] pulse = 6'h00;
	logic [1:0] portRole = 2'h0;
	logic [2:0] reqMode = 3'h0;
	logic [2:0] requestMode, protocolMode;
	logic testRequest, testActive, toDefault, disconnect, contractActive;
	logic [3:0] peState;
	logic [10:0] expQ[$];
	int err_count = 0;
	int samples_checked = 0;
	int n;
	always #12.5 clock = ~clock;
	bist_test_partner u_partner (.clock(clock), .sendReq(sendReq), .reqMode(reqMode),
		.testRequest(testRequest), .requestMode(requestMode));
	bist_continuous_mode_control #(.TEST_CYCLES(20)) u_dut (.clock(clock), .resetn(resetn),
		.clockEnable(clockEnable), .portRole(portRole), .testRequest(testRequest),
		.requestMode(requestMode), .busAtSafeLevel(busAtSafeLevel),
		.operatorReset(pulse[4]), .hardResetRx(pulse[3]), .fatalError(pulse[2]),
		.reconnected(pulse[1]), .contractMade(pulse[5]), .defaultDone(pulse[0]),
		.protocolMode(protocolMode), .testActive(testActive), .toDefault(toDefault),
		.disconnect(disconnect), .contractActive(contractActive), .peState(peState));
	// Compare seen against expected, count both
	task automatic check(input logic [10:0] seen, input logic [10:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check
	// Drive one cycle of inputs, note the result of the coming edge
	task automatic nx(input logic sr, input logic [5:0] p, input logic [3:0] s,
		input logic [2:0] m, input logic [3:0] f);
		sendReq = sr;
		pulse = p;
		expQ.push_back({s, m, f});
		@(negedge clock);
	endtask : nx
	task automatic end_of_test();
		$display("mismatches %0d, checks %0d", err_count, samples_checked);
		if (err_count == 0 && samples_checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : end_of_test
	// Outputs gathered in note order
	assign outs = {peState, protocolMode, testActive, toDefault, disconnect, contractActive};
	// Oldest note against the settled outputs after each edge
	always @(posedge clock) begin
		#1;
		if (expQ.size() > 0) check(outs, expQ.pop_front());
	end
	// Watchdog
	initial begin
		#(2000 * 25);
		err_count++;
		end_of_test();
	end
	// Main sequence
	initial begin
		void'($urandom(5));
		repeat (10) @(negedge clock);
		resetn = 1'b1;
		// Every mode from source ready; odd modes end early, even ones on the timer
		for (int m = 1; m <= 5; m++) begin
			reqMode = 3'(m);
			nx(1'b1, 6'h00, 4'(m + 2), 3'(m), 4'h8);
			n = (m % 2 == 1) ? $urandom_range(0, 8) : 19;
			repeat (n) nx(1'b0, 6'h00, 4'(m + 2), 3'(m), 4'h8);
			// Timer runs out, or operator reset, or hard reset for mode 3
			endPulse = (m == 3) ? 6'h08 : ((m % 2 == 1) ? 6'h10 : 6'h00);
			nx(1'b0, endPulse, 4'h8, 3'h0, 4'h4);
			nx(1'b0, 6'h01, 4'h0, 3'h0, 4'h0);
		end
		// Refused: bus not at safe level, then mode none and mode codes outside the table
		busAtSafeLevel = 1'b0;
		reqMode = 3'($urandom_range(1, 5));
		nx(1'b1, 6'h00, 4'h0, 3'h0, 4'h0);
		busAtSafeLevel = 1'b1;
		for (int m = 0; m < 3; m++) begin
			reqMode = (m == 0) ? 3'h0 : 3'(m + 5);
			nx(1'b1, 6'h00, 4'h0, 3'h0, 4'h0);
		end
		// Cable plug: hard reset and operator reset both return to cable ready
		portRole = 2'h2;
		nx(1'b0, 6'h00, 4'h2, 3'h0, 4'h0);
		reqMode = 3'h5;
		nx(1'b1, 6'h00, 4'h7, 3'h5, 4'h8);
		nx(1'b0, 6'h08, 4'h2, 3'h0, 4'h0);
		reqMode = 3'h1;
		nx(1'b1, 6'h00, 4'h3, 3'h1, 4'h8);
		nx(1'b0, 6'h10, 4'h2, 3'h0, 4'h0);
		// Sink: contract, carrier 1, then an unrecoverable error
		portRole = 2'h1;
		nx(1'b0, 6'h00, 4'h1, 3'h0, 4'h0);
		nx(1'b0, 6'h20, 4'h1, 3'h0, 4'h1);
		reqMode = 3'h3;
		nx(1'b1, 6'h00, 4'h5, 3'h3, 4'h9);
		nx(1'b0, 6'h04, 4'h9, 3'h0, 4'h2);
		nx(1'b0, 6'h02, 4'h1, 3'h0, 4'h0);
		// Frozen by clock enable, then a reset of the unit in mid-test
		reqMode = 3'h1;
		nx(1'b1, 6'h00, 4'h3, 3'h1, 4'h8);
		clockEnable = 1'b0;
		nx(1'b0, 6'h04, 4'h3, 3'h1, 4'h8);
		clockEnable = 1'b1;
		resetn = 1'b0;
		nx(1'b0, 6'h00, 4'h0, 3'h0, 4'h0);
		resetn = 1'b1;
		nx(1'b0, 6'h00, 4'h1, 3'h0, 4'h0);
		@(negedge clock);
		end_of_test();
	end
endmodule : bist_continuous_mode_control_tb
